// ### rtl/adcc_pkg.sv
/*
  Shared constants of the converter control block: register offsets,
  field positions, reset values and sequencing counts.
  Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
*/
package adcc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CHANNEL_CONTROL_STATUS = 5'h00;
  localparam logic [4:0] OFF_TRIGGER_COMPARE_STATUS = 5'h04;
  localparam logic [4:0] OFF_RESULT_HIGH = 5'h08;
  localparam logic [4:0] OFF_RESULT_LOW = 5'h0C;
  localparam logic [4:0] OFF_COMPARE_VALUE_HIGH = 5'h10;
  localparam logic [4:0] OFF_COMPARE_VALUE_LOW = 5'h14;
  localparam logic [4:0] OFF_CONVERTER_CONFIGURATION = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_COMPLETE = 7;
  localparam int BIT_IRQ_ENABLE = 6;
  localparam int BIT_CONTINUOUS = 5;
  localparam int BIT_IN_PROGRESS = 7;
  localparam int BIT_TRIGGER_SELECT = 6;
  localparam int BIT_COMPARE_ENABLE = 5;
  localparam int BIT_COMPARE_DIRECTION = 4;
  localparam int BIT_LOW_POWER = 7;
  localparam int POS_DIVIDER = 5;
  localparam int BIT_SAMPLE_LENGTH = 4;
  localparam int POS_MODE = 2;
  localparam int POS_CLOCK_SELECT = 0;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] CHANNEL_OFF = 5'h1F;
  localparam logic [1:0] MODE_EIGHT_BIT = 2'h0;
  localparam logic [1:0] MODE_TEN_BIT = 2'h2;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALTERNATE = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [4:0] RST_CHANNEL = 5'h1F;
  localparam logic [7:0] RST_CONFIGURATION = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Sequencing counts, in converter clock half-periods (divider ticks)
  // ----------------------------------------------------------------
  localparam logic [5:0] SAMPLE_SHORT_TICKS = 6'h02;
  localparam logic [5:0] SAMPLE_LONG_TICKS = 6'h14;
  localparam logic [5:0] BITS_EIGHT = 6'h08;
  localparam logic [5:0] BITS_TEN = 6'h0A;

endpackage

// ### rtl/adcc_clkdiv.sv
/*
  Converter clock generator: picks one of four sources and divides it.
  Assumes the alternate and asynchronous clock inputs are slow levels
  already synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_clkdiv
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selection
  input wire logic [1:0] clock_select,
  input wire logic [1:0] divider,
  input wire logic alternate_clock,
  input wire logic module_async_clock,
  // Output
  output logic tick,
  output logic converter_clock
);

  logic half_reg;
  logic alt_prev_reg;
  logic async_prev_reg;
  logic [2:0] count_reg;
  logic clk_reg;
  logic src_tick;
  logic [2:0] limit;

  // Source edge per input clock select
  assign src_tick = (clock_select == CLK_BUS) ? 1'b1 :
                    (clock_select == CLK_BUS_HALF) ? half_reg :
                    (clock_select == CLK_ALTERNATE) ? (alternate_clock & ~alt_prev_reg) :
                    (module_async_clock & ~async_prev_reg);
  // Divide ratio 1, 2, 4 or 8
  assign limit = (3'h1 << divider) - 3'h1;
  assign tick = src_tick && (count_reg == limit);
  assign converter_clock = clk_reg;

  // Source edge trackers and divide counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      half_reg <= 1'b0;
      alt_prev_reg <= 1'b0;
      async_prev_reg <= 1'b0;
      count_reg <= 3'h0;
      clk_reg <= 1'b0;
    end
    else
    begin
      half_reg <= ~half_reg;
      alt_prev_reg <= alternate_clock;
      async_prev_reg <= module_async_clock;
      if (src_tick)
        count_reg <= tick ? 3'h0 : count_reg + 3'h1;
      if (tick)
        clk_reg <= ~clk_reg;
    end
  end

endmodule

`default_nettype wire

// ### rtl/adcc_top.sv
/*
  Register-side control of a successive approximation converter:
  trigger selection, conversion sequencing, automatic compare, result
  registers with read interlock, and configuration, over AXI4-Lite.
  Assumes the analog core presents its result on core_result when the
  conversion ends, and that all inputs are synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_top
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 5
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger and clock sources
  input wire logic hardware_trigger_input,
  input wire logic alternate_clock,
  input wire logic module_async_clock,
  // Analog core
  input wire logic [9:0] core_result,
  output logic converter_clock,
  output logic sample_active,
  output logic converter_enable,
  output logic low_power_config,
  output logic ten_bit_mode,
  output logic [4:0] channel_select_field,
  // Status
  output logic conversion_in_progress,
  output logic conversion_complete_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Compare condition for the current mode
  function automatic logic compare_hit(input logic [9:0] res, input logic [9:0] val, input logic ten,
                                       input logic dir);
    logic [9:0] a;
    logic [9:0] b;
    a = ten ? res : {2'h0, res[7:0]};
    b = ten ? val : {2'h0, val[7:0]};
    compare_hit = dir ? (a >= b) : (a < b);
  endfunction

  // Registers sit densely from offset zero, one aligned word each
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a <= OFF_CONVERTER_CONFIGURATION) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic aw_held_reg, w_held_reg, wstrb_reg, bvalid_reg, rvalid_reg, irq_enable_reg, continuous_reg;
  logic trigger_select_reg, compare_enable_reg, compare_direction_reg, lock_reg, complete_reg, hw_prev_reg;
  logic busy_reg, sampling_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg, compare_low_reg, config_reg;
  logic [1:0] bresp_reg, rresp_reg, compare_high_reg;
  logic [31:0] rdata_reg;
  logic [4:0] channel_reg;
  logic [9:0] result_reg;
  logic [5:0] count_reg, count_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_en, rd_en, wr_known, rd_known, wr_sc1, wr_sc2, wr_cvh, wr_cvl, wr_cfg, rd_rh, rd_rl;
  logic [7:0] rd_byte;

  // Write fires once both address and data are held
  assign wr_en = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Write targets; lane 0 carries every register
  assign wr_sc1 = wr_en && wstrb_reg && (awaddr_reg == OFF_CHANNEL_CONTROL_STATUS);
  assign wr_sc2 = wr_en && wstrb_reg && (awaddr_reg == OFF_TRIGGER_COMPARE_STATUS);
  assign wr_cvh = wr_en && wstrb_reg && (awaddr_reg == OFF_COMPARE_VALUE_HIGH);
  assign wr_cvl = wr_en && wstrb_reg && (awaddr_reg == OFF_COMPARE_VALUE_LOW);
  assign wr_cfg = wr_en && wstrb_reg && (awaddr_reg == OFF_CONVERTER_CONFIGURATION);
  assign wr_known = mapped(awaddr_reg);

  // Read targets with side effects
  assign rd_rh = rd_en && (s_axi_araddr == OFF_RESULT_HIGH);
  assign rd_rl = rd_en && (s_axi_araddr == OFF_RESULT_LOW);
  assign rd_known = mapped(s_axi_araddr);

  // Read data mux; reserved bits read as zero
  assign rd_byte =
    (s_axi_araddr == OFF_CHANNEL_CONTROL_STATUS) ?
      {complete_reg, irq_enable_reg, continuous_reg, channel_reg} :
    (s_axi_araddr == OFF_TRIGGER_COMPARE_STATUS) ?
      {busy_reg, trigger_select_reg, compare_enable_reg, compare_direction_reg, 4'h0} :
    (s_axi_araddr == OFF_RESULT_HIGH) ? {6'h00, ten_bit_mode ? result_reg[9:8] : 2'h0} :
    (s_axi_araddr == OFF_RESULT_LOW) ? result_reg[7:0] :
    (s_axi_araddr == OFF_COMPARE_VALUE_HIGH) ? {6'h00, compare_high_reg} :
    (s_axi_araddr == OFF_COMPARE_VALUE_LOW) ? compare_low_reg :
    (s_axi_araddr == OFF_CONVERTER_CONFIGURATION) ? config_reg : 8'h00;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  logic long_sample, mode_change;
  logic [1:0] mode_field;

  assign low_power_config = config_reg[BIT_LOW_POWER];
  assign long_sample = config_reg[BIT_SAMPLE_LENGTH];
  assign mode_field = config_reg[POS_MODE +: 2];
  assign ten_bit_mode = (mode_field == MODE_TEN_BIT);
  assign mode_change = wr_cfg && (wdata_reg[POS_MODE +: 2] != mode_field);
  assign channel_select_field = channel_reg;
  assign converter_enable = (channel_reg != CHANNEL_OFF);

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  logic tick;

  adcc_clkdiv u_clkdiv
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_select(config_reg[POS_CLOCK_SELECT +: 2]),
    .divider(config_reg[POS_DIVIDER +: 2]),
    .alternate_clock(alternate_clock),
    .module_async_clock(module_async_clock),
    .tick(tick),
    .converter_clock(converter_clock)
  );

  // ----------------------------------------------------------------
  // Trigger and sequencing
  // ----------------------------------------------------------------
  logic sw_start, hw_start, cont_start, start, abort, done;
  logic [5:0] sample_ticks, bit_ticks;

  assign sw_start = wr_sc1 && !trigger_select_reg && (wdata_reg[4:0] != CHANNEL_OFF);
  assign hw_start = trigger_select_reg && hardware_trigger_input && !hw_prev_reg && !busy_reg &&
                    converter_enable && !wr_sc1;
  assign abort = wr_sc1;
  assign done = busy_reg && tick && (count_reg == 6'h01) && !abort;
  assign cont_start = done && continuous_reg && converter_enable;
  assign start = sw_start || hw_start || cont_start;
  assign sample_ticks = long_sample ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS;
  assign bit_ticks = ten_bit_mode ? BITS_TEN : BITS_EIGHT;
  assign count_next = start ? (sample_ticks + bit_ticks) : (tick && busy_reg) ? count_reg - 6'h01 : count_reg;
  assign conversion_in_progress = busy_reg;
  assign sample_active = sampling_reg;

  // Conversion counter and in-progress flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_reg <= 1'b0;
      count_reg <= 6'h00;
      sampling_reg <= 1'b0;
      hw_prev_reg <= 1'b0;
    end
    else
    begin
      hw_prev_reg <= hardware_trigger_input;
      count_reg <= count_next;
      busy_reg <= start || (busy_reg && !abort && !done);
      sampling_reg <= start || (sampling_reg && !abort && !done && (count_next > bit_ticks));
    end
  end

  // ----------------------------------------------------------------
  // Result transfer and compare
  // ----------------------------------------------------------------
  logic [9:0] sample_value;
  logic hit, accept, transfer;

  assign sample_value = ten_bit_mode ? core_result : {2'h0, core_result[7:0]};
  assign hit = compare_hit(sample_value, {compare_high_reg, compare_low_reg}, ten_bit_mode, compare_direction_reg);
  assign accept = done && (!compare_enable_reg || hit);
  assign transfer = accept && !(ten_bit_mode && lock_reg) && !mode_change;

  // Result, interlock and complete flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_reg <= 10'h000;
      lock_reg <= 1'b0;
      complete_reg <= 1'b0;
    end
    else
    begin
      if (mode_change)
        result_reg <= 10'h000;
      else if (transfer)
        result_reg <= sample_value;
      if (mode_change || rd_rl)
        lock_reg <= 1'b0;
      else if (rd_rh && ten_bit_mode)
        lock_reg <= 1'b1;
      if (accept)
        complete_reg <= 1'b1;
      else if (wr_sc1 || rd_rl)
        complete_reg <= 1'b0;
    end
  end

  assign conversion_complete_flag = complete_reg;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_enable_reg <= 1'b0;
      continuous_reg <= 1'b0;
      channel_reg <= RST_CHANNEL;
      trigger_select_reg <= 1'b0;
      compare_enable_reg <= 1'b0;
      compare_direction_reg <= 1'b0;
      compare_high_reg <= 2'h0;
      compare_low_reg <= 8'h00;
      config_reg <= RST_CONFIGURATION;
    end
    else
    begin
      if (wr_sc1)
      begin
        irq_enable_reg <= wdata_reg[BIT_IRQ_ENABLE];
        continuous_reg <= wdata_reg[BIT_CONTINUOUS];
        channel_reg <= wdata_reg[4:0];
      end
      // Reserved low bits are not stored
      if (wr_sc2)
      begin
        trigger_select_reg <= wdata_reg[BIT_TRIGGER_SELECT];
        compare_enable_reg <= wdata_reg[BIT_COMPARE_ENABLE];
        compare_direction_reg <= wdata_reg[BIT_COMPARE_DIRECTION];
      end
      if (wr_cvh)
        compare_high_reg <= wdata_reg[1:0];
      if (wr_cvl)
        compare_low_reg <= wdata_reg;
      if (wr_cfg)
        config_reg <= wdata_reg;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite channel handshakes
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
      end
      if (wr_en)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Read answer registered one cycle after address acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else if (rd_en)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h0, rd_byte};
      rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

endmodule

`default_nettype wire

// ### verif/adcc_top_asserts.sv
/*
  Protocol and status checker for the converter control block.
  Assumes it is bound to adcc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_top_asserts
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 5
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter status
  input wire logic sample_active,
  input wire logic converter_enable,
  input wire logic ten_bit_mode,
  input wire logic [4:0] channel_select_field,
  input wire logic conversion_in_progress,
  input wire logic conversion_complete_flag
);
  // ----------------------------------------------------------------
  // Single clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Responses stand until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped or changed early");
  // One transfer at a time
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write accepted while response pending");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read accepted while data pending");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read returned data");
  // Converter off when channel field is all ones
  property p_enable;
    converter_enable == (channel_select_field != CHANNEL_OFF);
  endproperty
  a_enable: assert property (p_enable) else $error("converter enable wrong");
  // High result holds two bits, zero in 8-bit mode
  property p_rh_zero;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_RESULT_HIGH
      |=> s_axi_rdata[31:2] == 30'h0 && (ten_bit_mode || s_axi_rdata[1:0] == 2'h0);
  endproperty
  a_rh_zero: assert property (p_rh_zero) else $error("high result bits wrong");
  // Low result read clears the complete flag
  property p_cc_clear;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_RESULT_LOW && !conversion_in_progress
      |=> !conversion_complete_flag;
  endproperty
  a_cc_clear: assert property (p_cc_clear) else $error("complete flag not cleared");
  // Conversion opens with sampling
  property p_sample;
    $rose(conversion_in_progress) |-> sample_active;
  endproperty
  a_sample: assert property (p_sample) else $error("no sampling at conversion start");
endmodule

bind adcc_top adcc_top_asserts #(.ADDR_W(ADDR_W)) i_adcc_top_asserts (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .sample_active, .converter_enable, .ten_bit_mode, .channel_select_field,
  .conversion_in_progress, .conversion_complete_flag);
`default_nettype wire

// ### verif/adcc_core_model.sv
/*
  Far-side model: analog core result, trigger source and slow clocks.
  Assumes the bench sets the analog level and trigger request.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_core_model
(
  // Clock and stimulus
  input wire logic aclk,
  input wire logic [9:0] level,
  input wire logic trig_req,
  input wire logic converter_enable,
  // To the block
  output logic [9:0] core_result,
  output logic hardware_trigger_input,
  output logic alternate_clock,
  output logic module_async_clock
);
  logic [2:0] cnt_reg = 3'h0;

  // Trigger registered off the bus clock, slow source clocks
  always_ff @(posedge aclk)
  begin
    cnt_reg <= cnt_reg + 3'h1;
    hardware_trigger_input <= trig_req;
  end
  assign alternate_clock = cnt_reg[1];
  assign module_async_clock = cnt_reg[2];
  // A disabled core shows no stale level
  assign core_result = converter_enable ? level : ~level;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/*
  Self-checking bench of the converter control block.
  Assumes a single 10 MHz clock and the core model on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("Error %0t %0h %0h", $time, a, b); end end

module tb_top
  import adcc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, trig_req = 1'b0;
  logic [9:0] level = 10'h000;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  wire logic awready, wready, bvalid, arready, rvalid, conv_clk, samp, cen, lowp, tenb, busy, cc, hw_trig, altc, asyc;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [9:0] core_result;
  wire logic [4:0] chan;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc;

  adcc_top i_adcc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hardware_trigger_input(hw_trig), .alternate_clock(altc),
    .module_async_clock(asyc), .core_result(core_result), .converter_clock(conv_clk), .sample_active(samp),
    .converter_enable(cen), .low_power_config(lowp), .ten_bit_mode(tenb), .channel_select_field(chan),
    .conversion_in_progress(busy), .conversion_complete_flag(cc));
  adcc_core_model i_adcc_core_model (.aclk, .level, .trig_req, .converter_enable(cen), .core_result,
    .hardware_trigger_input(hw_trig), .alternate_clock(altc), .module_async_clock(asyc));

  // ----------------------------------------------------------------
  // Clock, bus tasks and helpers
  // ----------------------------------------------------------------
  initial
  begin
    forever #50 aclk = ~aclk;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
      bready <= 1'b1;
    end
    `CHK(bresp, RESP_OKAY)
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
      rready <= 1'b1;
    end
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_data, {24'h0, e})
    `CHK(rd_resp, RESP_OKAY)
  endtask
  // Bounded wait for the busy flag
  task automatic wait_busy(input logic v, input int lim);
    cyc = 0;
    while (busy !== v && cyc < lim)
    begin
      @(posedge aclk);
      cyc++;
    end
    `CHK(busy, v)
  endtask
  task automatic conv(input logic [4:0] ch);
    wr(OFF_CHANNEL_CONTROL_STATUS, {3'h0, ch});
    wait_busy(1'b1, 6);
    wait_busy(1'b0, 3000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(OFF_CHANNEL_CONTROL_STATUS, 8'h1F);
    rchk(OFF_TRIGGER_COMPARE_STATUS, 8'h00);
    rchk(OFF_CONVERTER_CONFIGURATION, 8'h00);
    rd(5'h1C);
    `CHK(rd_resp, RESP_SLVERR)
    wr(OFF_RESULT_LOW, 8'hFF);
    rchk(OFF_RESULT_LOW, 8'h00);
  endtask
  task automatic t_soft;
    logic ck;
    ck = conv_clk;
    @(posedge aclk);
    `CHK(conv_clk, ~ck)
    level <= 10'h2A5;
    conv(5'h03);
    `CHK(cc, 1'b1)
    rchk(OFF_RESULT_HIGH, 8'h00);
    rchk(OFF_RESULT_LOW, 8'hA5);
    @(posedge aclk);
    `CHK(cc, 1'b0)
    conv(5'h03);
    wr(OFF_CHANNEL_CONTROL_STATUS, 8'h1F);
    `CHK(cc, 1'b0)
  endtask
  task automatic t_hw;
    wr(OFF_TRIGGER_COMPARE_STATUS, 8'h40);
    rchk(OFF_TRIGGER_COMPARE_STATUS, 8'h40);
    level <= 10'h03C;
    wr(OFF_CHANNEL_CONTROL_STATUS, 8'h02);
    repeat (4) @(posedge aclk);
    `CHK(busy, 1'b0)
    trig_req <= 1'b1;
    wait_busy(1'b1, 6);
    trig_req <= 1'b0;
    rchk(OFF_TRIGGER_COMPARE_STATUS, 8'hC0);
    wait_busy(1'b0, 3000);
    rchk(OFF_RESULT_LOW, 8'h3C);
    wr(OFF_TRIGGER_COMPARE_STATUS, 8'h00);
  endtask
  task automatic t_cmp;
    logic [7:0] ctl [6] = '{8'h00, 8'h20, 8'h20, 8'h30, 8'h30, 8'h00};
    logic [9:0] lv [6] = '{10'h011, 10'h090, 10'h07F, 10'h07F, 10'h081, 10'h090};
    logic ld [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [7:0] exp_v;
    wr(OFF_COMPARE_VALUE_HIGH, 8'h03);
    wr(OFF_COMPARE_VALUE_LOW, 8'h80);
    for (int i = 0; i < 6; i++)
    begin
      wr(OFF_TRIGGER_COMPARE_STATUS, ctl[i]);
      level <= lv[i];
      conv(5'h03);
      `CHK(cc, ld[i])
      if (ld[i]) exp_v = lv[i][7:0];
      rchk(OFF_RESULT_LOW, exp_v);
    end
  endtask
  task automatic t_ten;
    wr(OFF_CONVERTER_CONFIGURATION, 8'h08);
    `CHK(tenb, 1'b1)
    wr(OFF_COMPARE_VALUE_HIGH, 8'h02);
    wr(OFF_COMPARE_VALUE_LOW, 8'h00);
    wr(OFF_TRIGGER_COMPARE_STATUS, 8'h30);
    level <= 10'h1FF;
    conv(5'h03);
    `CHK(cc, 1'b0)
    level <= 10'h2AA;
    conv(5'h03);
    rchk(OFF_RESULT_HIGH, 8'h02);
    level <= 10'h3CC;
    conv(5'h03);
    rchk(OFF_RESULT_LOW, 8'hAA);
    level <= 10'h355;
    conv(5'h03);
    rchk(OFF_RESULT_HIGH, 8'h03);
    rchk(OFF_RESULT_LOW, 8'h55);
    wr(OFF_CONVERTER_CONFIGURATION, 8'h00);
    `CHK(tenb, 1'b0)
    rchk(OFF_RESULT_LOW, 8'h00);
    wr(OFF_TRIGGER_COMPARE_STATUS, 8'h00);
    rchk(OFF_RESULT_HIGH, 8'h00);
    level <= 10'h0C3;
    conv(5'h03);
    rchk(OFF_RESULT_LOW, 8'hC3);
  endtask
  task automatic t_clk;
    logic [7:0] cfg [9] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h10, 8'h80, 8'h02, 8'h03};
    int len [9] = '{10, 20, 40, 80, 20, 28, 10, 40, 80};
    for (int i = 0; i < 9; i++)
    begin
      wr(OFF_CONVERTER_CONFIGURATION, cfg[i]);
      `CHK(lowp, cfg[i][7])
      level <= {2'h0, cfg[i] ^ 8'h5A};
      conv(5'h03);
      `CHK(cyc >= len[i] - len[i] / 10 && cyc <= len[i] + len[i] / 10, 1'b1)
      rchk(OFF_RESULT_LOW, cfg[i] ^ 8'h5A);
    end
  endtask
  task automatic t_abort;
    wr(OFF_CONVERTER_CONFIGURATION, 8'h60);
    wr(OFF_CHANNEL_CONTROL_STATUS, 8'h03);
    repeat (10) @(posedge aclk);
    wr(OFF_CHANNEL_CONTROL_STATUS, 8'h1F);
    wait_busy(1'b0, 4);
    `CHK(cen, 1'b0)
    wr(OFF_CHANNEL_CONTROL_STATUS, 8'h03);
    repeat (20) @(posedge aclk);
    wr(OFF_CHANNEL_CONTROL_STATUS, 8'h04);
    `CHK(busy, 1'b1)
    wait_busy(1'b0, 3000);
    `CHK(cyc >= 70, 1'b1)
    `CHK(chan, 5'h04)
    wr(OFF_CONVERTER_CONFIGURATION, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic test_done;
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_soft();
    t_hw();
    t_cmp();
    t_ten();
    t_clk();
    t_abort();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
